// ---- shared/ispfsm_pkg.sv ----
// Shared constants and types of the isolated supply protection supervisor
`default_nettype none
package ispfsm_pkg;
	localparam int SYNC_STAGES = 2;
	localparam int CLK_PERIOD_NS = 10;
	localparam int SS_TIMEOUT_US = 28400;
	localparam int SS_TIMEOUT_CYCLES = (SS_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
	localparam int SS_RAMP_US = 1024;
	localparam int SS_RAMP_CYCLES = ((SS_RAMP_US * 1000) + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PG_DEGLITCH_US = 3000;
	localparam int PG_DEGLITCH_CYCLES = ((PG_DEGLITCH_US * 1000) + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int N_COMP = 12;
	// Comparator and enable bit positions in the synchronised vector
	localparam int B_IN_LOW = 0;
	localparam int B_IN_RESET = 1;
	localparam int B_IN_HIGH = 2;
	localparam int B_POS_LOW = 3;
	localparam int B_NEG_LOW = 4;
	localparam int B_POS_RISE = 5;
	localparam int B_NEG_RISE = 6;
	localparam int B_POS_HIGH = 7;
	localparam int B_NEG_HIGH = 8;
	localparam int B_FAILSAFE = 9;
	localparam int B_HOT = 10;
	localparam int B_ENABLE = 11;
	typedef enum logic [2:0] {
		ST_LOCKOUT = 3'h0,
		ST_DISABLE = 3'h1,
		ST_SOFTSTART = 3'h2,
		ST_NORMAL = 3'h3,
		ST_LATCHED = 3'h4
	} ispfsm_state_t;
	typedef enum logic [2:0] {
		CAUSE_NONE = 3'h0,
		CAUSE_UNDER = 3'h1,
		CAUSE_OVER = 3'h2,
		CAUSE_FAILSAFE = 3'h3,
		CAUSE_HOT = 3'h4,
		CAUSE_TIMEOUT = 3'h5
	} ispfsm_cause_t;
endpackage
`default_nettype wire

// ---- shared/ispfsm_sync_if.sv ----
// Carrier between the synchroniser and the mode logic
`default_nettype none
interface ispfsm_sync_if #(parameter int WIDTH = 12);
	logic [WIDTH-1:0] raw;
	logic [WIDTH-1:0] synced;
	modport src (input raw, output synced);
	modport dst (output raw, input synced);
endinterface
`default_nettype wire

// ---- hw/ispfsm_sync.sv ----
// Two-flop synchroniser bank for comparator and enable inputs
`default_nettype none
module ispfsm_sync (
	input wire logic i_mclk,
	input wire logic i_reset,
	ispfsm_sync_if.src bus
);
	localparam int W = $bits(bus.raw);
	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			always_ff @(posedge i_mclk) begin
				if (i_reset) begin
					stage1[g] <= 1'b0;
					stage2[g] <= 1'b0;
				end else begin
					stage1[g] <= bus.raw[g];
					stage2[g] <= stage1[g];
				end
			end
		end
	endgenerate
	assign bus.synced = stage2;
endmodule
`default_nettype wire

// ---- hw/ispfsm_top.sv ----
// Protection and operating mode supervisor of the isolated supply
`default_nettype none
module ispfsm_top #(
	parameter int SS_TIMEOUT = ispfsm_pkg::SS_TIMEOUT_CYCLES,
	parameter int SS_RAMP = ispfsm_pkg::SS_RAMP_CYCLES,
	parameter int PG_DEGLITCH = ispfsm_pkg::PG_DEGLITCH_CYCLES
) (
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_input_low_lockout,
	input wire logic i_input_reset_level,
	input wire logic i_input_high_lockout,
	input wire logic i_pos_low_fall,
	input wire logic i_neg_low_fall,
	input wire logic i_pos_low_rise,
	input wire logic i_neg_low_rise,
	input wire logic i_pos_high_rise,
	input wire logic i_neg_high_rise,
	input wire logic i_rail_failsafe,
	input wire logic i_primary_hot,
	input wire logic i_secondary_hot,
	input wire logic i_converter_on_request,
	input wire logic i_converter_on_request_driven,
	output logic o_switch_enable,
	output logic o_softstart_start,
	output logic o_softstart_active,
	output logic o_supply_good_n_out,
	output logic o_supply_good_n_oe,
	output logic [2:0] o_mode,
	output logic [2:0] o_latch_cause
);
	ispfsm_sync_if #(.WIDTH(ispfsm_pkg::N_COMP)) sbus ();
	logic [ispfsm_pkg::N_COMP-1:0] s;
	logic enable_pin;
	ispfsm_pkg::ispfsm_state_t state;
	ispfsm_pkg::ispfsm_state_t next_state;
	ispfsm_pkg::ispfsm_cause_t cause;
	ispfsm_pkg::ispfsm_cause_t next_cause;
	logic enable_prev;
	logic enable_fall_seen;
	logic [31:0] ss_count;
	logic [31:0] pg_count;
	logic in_range;
	logic uv_now;
	logic ov_now;
	logic fs_now;
	logic hot_now;
	logic ss_done;
	logic ss_timeout;
	logic rails_rise_ok;
	logic clear_latch;
	logic good_window;

	// Floating enable reads low, mimicking the internal weak pull-down
	assign enable_pin = i_converter_on_request_driven & i_converter_on_request;

	assign sbus.raw = {enable_pin, i_primary_hot | i_secondary_hot, i_rail_failsafe,
		i_neg_high_rise, i_pos_high_rise, i_neg_low_rise, i_pos_low_rise,
		i_neg_low_fall, i_pos_low_fall, i_input_high_lockout,
		i_input_reset_level, i_input_low_lockout};

	ispfsm_sync u_sync (
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.bus(sbus)
	);
	assign s = sbus.synced;

	assign in_range = !s[ispfsm_pkg::B_IN_LOW] && !s[ispfsm_pkg::B_IN_HIGH];
	assign uv_now = s[ispfsm_pkg::B_POS_LOW] || s[ispfsm_pkg::B_NEG_LOW];
	assign ov_now = s[ispfsm_pkg::B_POS_HIGH] || s[ispfsm_pkg::B_NEG_HIGH];
	assign fs_now = s[ispfsm_pkg::B_FAILSAFE];
	assign hot_now = s[ispfsm_pkg::B_HOT];
	assign rails_rise_ok = s[ispfsm_pkg::B_POS_RISE] && s[ispfsm_pkg::B_NEG_RISE];
	assign ss_done = (ss_count >= 32'(SS_RAMP));
	assign ss_timeout = (ss_count >= 32'(SS_TIMEOUT)) && !s[ispfsm_pkg::B_POS_RISE];
	// Only the rising edge or the input reset level clears; a toggle made while still faulty is spent
	assign clear_latch = s[ispfsm_pkg::B_IN_RESET]
		|| (enable_fall_seen && !enable_prev && s[ispfsm_pkg::B_ENABLE] && !hot_now && !uv_now
		&& !ov_now && !fs_now);

	// Enable falling edge remembered in latched mode until the next rising edge of enable
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			enable_prev <= 1'b0;
			enable_fall_seen <= 1'b0;
		end else begin
			enable_prev <= s[ispfsm_pkg::B_ENABLE];
			if (state != ispfsm_pkg::ST_LATCHED) begin
				enable_fall_seen <= 1'b0;
			end else if (enable_prev && !s[ispfsm_pkg::B_ENABLE]) begin
				enable_fall_seen <= 1'b1;
			end else if (!enable_prev && s[ispfsm_pkg::B_ENABLE]) begin
				enable_fall_seen <= 1'b0;
			end
		end
	end

	always_comb begin
		next_state = state;
		next_cause = cause;
		case (state)
			ispfsm_pkg::ST_LOCKOUT: begin
				if (in_range) begin
					if (cause != ispfsm_pkg::CAUSE_NONE) begin
						next_state = ispfsm_pkg::ST_LATCHED;
					end else if (s[ispfsm_pkg::B_ENABLE]) begin
						next_state = ispfsm_pkg::ST_SOFTSTART;
					end else begin
						next_state = ispfsm_pkg::ST_DISABLE;
					end
				end
			end
			ispfsm_pkg::ST_DISABLE: begin
				if (s[ispfsm_pkg::B_ENABLE]) begin
					next_state = ispfsm_pkg::ST_SOFTSTART;
				end
			end
			ispfsm_pkg::ST_SOFTSTART: begin
				if (!s[ispfsm_pkg::B_ENABLE]) begin
					next_state = ispfsm_pkg::ST_DISABLE;
				end else if (fs_now || ov_now) begin
					next_state = ispfsm_pkg::ST_LATCHED;
					next_cause = fs_now ? ispfsm_pkg::CAUSE_FAILSAFE : ispfsm_pkg::CAUSE_OVER;
				end else if (hot_now) begin
					next_state = ispfsm_pkg::ST_LATCHED;
					next_cause = ispfsm_pkg::CAUSE_HOT;
				end else if (ss_timeout) begin
					next_state = ispfsm_pkg::ST_LATCHED;
					next_cause = ispfsm_pkg::CAUSE_TIMEOUT;
				end else if (ss_done && s[ispfsm_pkg::B_POS_RISE]) begin
					// Undervoltage ignored until here, rails start from zero
					if (rails_rise_ok) begin
						next_state = ispfsm_pkg::ST_NORMAL;
					end else begin
						next_state = ispfsm_pkg::ST_LATCHED;
						next_cause = ispfsm_pkg::CAUSE_UNDER;
					end
				end
			end
			ispfsm_pkg::ST_NORMAL: begin
				if (!s[ispfsm_pkg::B_ENABLE]) begin
					next_state = ispfsm_pkg::ST_DISABLE;
				end else if (fs_now || ov_now) begin
					next_state = ispfsm_pkg::ST_LATCHED;
					next_cause = fs_now ? ispfsm_pkg::CAUSE_FAILSAFE : ispfsm_pkg::CAUSE_OVER;
				end else if (hot_now) begin
					next_state = ispfsm_pkg::ST_LATCHED;
					next_cause = ispfsm_pkg::CAUSE_HOT;
				end else if (uv_now) begin
					next_state = ispfsm_pkg::ST_LATCHED;
					next_cause = ispfsm_pkg::CAUSE_UNDER;
				end
			end
			ispfsm_pkg::ST_LATCHED: begin
				if (clear_latch) begin
					next_cause = ispfsm_pkg::CAUSE_NONE;
					next_state = s[ispfsm_pkg::B_ENABLE] ? ispfsm_pkg::ST_SOFTSTART : ispfsm_pkg::ST_DISABLE;
				end
			end
			default: begin
				next_state = ispfsm_pkg::ST_LOCKOUT;
			end
		endcase
		// Input lockouts override every mode but keep the latch cause
		if (!in_range) begin
			next_state = ispfsm_pkg::ST_LOCKOUT;
		end
		if (s[ispfsm_pkg::B_IN_RESET]) begin
			next_cause = ispfsm_pkg::CAUSE_NONE;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			state <= ispfsm_pkg::ST_LOCKOUT;
			cause <= ispfsm_pkg::CAUSE_NONE;
		end else begin
			state <= next_state;
			cause <= next_cause;
		end
	end

	// Soft-start ramp and timeout counter
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			ss_count <= 32'h00000000;
		end else if (state != ispfsm_pkg::ST_SOFTSTART) begin
			ss_count <= 32'h00000000;
		end else if (ss_count != 32'hFFFFFFFF) begin
			ss_count <= ss_count + 32'h00000001;
		end
	end

	// Settling delay in normal mode before good is reported
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			pg_count <= 32'h00000000;
		end else if (state != ispfsm_pkg::ST_NORMAL || uv_now || ov_now || fs_now || hot_now) begin
			pg_count <= 32'h00000000;
		end else if (pg_count < 32'(PG_DEGLITCH)) begin
			pg_count <= pg_count + 32'h00000001;
		end
	end
	assign good_window = (pg_count >= 32'(PG_DEGLITCH)) && rails_rise_ok;

	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			o_switch_enable <= 1'b0;
			o_softstart_start <= 1'b0;
			o_softstart_active <= 1'b0;
			o_supply_good_n_oe <= 1'b0;
			o_mode <= 3'h0;
			o_latch_cause <= 3'h0;
		end else begin
			o_switch_enable <= (next_state == ispfsm_pkg::ST_SOFTSTART)
				|| (next_state == ispfsm_pkg::ST_NORMAL);
			o_softstart_start <= (next_state == ispfsm_pkg::ST_SOFTSTART)
				&& (state != ispfsm_pkg::ST_SOFTSTART);
			o_softstart_active <= (next_state == ispfsm_pkg::ST_SOFTSTART);
			o_supply_good_n_oe <= (next_state == ispfsm_pkg::ST_NORMAL) && good_window;
			o_mode <= next_state;
			o_latch_cause <= next_cause;
		end
	end
	// Open drain: only ever pulls low
	assign o_supply_good_n_out = 1'b0;
endmodule
`default_nettype wire

// ---- verif/ispfsm_assertions.sv ----
// Concurrent checks on the supervisor ports
`default_nettype none
module ispfsm_checker (
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_input_low_lockout,
	input wire logic i_input_reset_level,
	input wire logic i_input_high_lockout,
	input wire logic i_pos_high_rise,
	input wire logic i_rail_failsafe,
	input wire logic i_primary_hot,
	input wire logic i_converter_on_request,
	input wire logic o_switch_enable,
	input wire logic o_softstart_start,
	input wire logic o_supply_good_n_out,
	input wire logic o_supply_good_n_oe,
	input wire logic [2:0] o_mode,
	input wire logic [2:0] o_latch_cause
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge i_mclk);
	endclocking
	default disable iff (i_reset);
	// Five samples cover the two flops plus the output register
	sequence held_on;
		(i_converter_on_request && !i_input_reset_level && !i_input_low_lockout && !i_input_high_lockout)[*5];
	endsequence
	sw_mode_a: assert property (o_switch_enable == (o_mode == 3'h2 || o_mode == 3'h3))
		else $error("switch enable disagrees with mode");
	good_mode_a: assert property (o_supply_good_n_oe |-> o_mode == 3'h3)
		else $error("good outside normal mode");
	good_data_a: assert property (!o_supply_good_n_out)
		else $error("good pin data not low");
	pulse_one_a: assert property (o_softstart_start |-> o_mode == 3'h2 ##1 !o_softstart_start)
		else $error("soft-start pulse wrong");
	low_stop_a: assert property (i_input_low_lockout[*5] |=> !o_switch_enable && !o_supply_good_n_oe)
		else $error("switching in input lockout");
	high_stop_a: assert property (i_input_high_lockout[*5] |=> !o_switch_enable)
		else $error("switching in overvoltage lockout");
	fb_over_a: assert property (i_pos_high_rise[*5] |=> !o_switch_enable)
		else $error("switching with feedback overvoltage");
	fail_safe_a: assert property (i_rail_failsafe[*5] |=> !o_switch_enable)
		else $error("switching with rail overvoltage");
	hot_stop_a: assert property (i_primary_hot[*5] |=> !o_switch_enable && !o_supply_good_n_oe)
		else $error("switching while hot");
	cause_clear_a: assert property (i_input_reset_level[*5] |=> o_latch_cause == 3'h0)
		else $error("cause kept under reset level");
	latch_hold_a: assert property (held_on ##0 o_mode == 3'h4 |=> o_mode == 3'h4)
		else $error("latch left without recycle");
endmodule
bind ispfsm_top ispfsm_checker chk_i (.i_mclk(i_mclk), .i_reset(i_reset),
	.i_input_low_lockout(i_input_low_lockout), .i_input_reset_level(i_input_reset_level),
	.i_input_high_lockout(i_input_high_lockout), .i_pos_high_rise(i_pos_high_rise),
	.i_rail_failsafe(i_rail_failsafe), .i_primary_hot(i_primary_hot),
	.i_converter_on_request(i_converter_on_request), .o_switch_enable(o_switch_enable),
	.o_softstart_start(o_softstart_start), .o_supply_good_n_out(o_supply_good_n_out),
	.o_supply_good_n_oe(o_supply_good_n_oe), .o_mode(o_mode), .o_latch_cause(o_latch_cause));
`default_nettype wire

// ---- verif/ispfsm_host.sv ----
// Host model driving the on request and reading the good pin
`default_nettype none
module ispfsm_host #(
	parameter int LOW_CYC = 8
) (
	input wire logic i_mclk,
	input wire logic i_want_on,
	input wire logic i_toggle,
	input wire logic i_pin_oe,
	output logic o_on_request,
	output logic o_good
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cnt = 8'h00;
	// Low hold scaled down from the long host hold
	always_ff @(posedge i_mclk) begin
		if (i_toggle) begin
			cnt <= 8'(LOW_CYC);
		end else if (cnt != 8'h00) begin
			cnt <= cnt - 8'h01;
		end
	end
	assign o_on_request = i_want_on && cnt == 8'h00;
	// Pulled up when released, so good means drain active
	assign o_good = i_pin_oe;
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking bench of the protection supervisor
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, rst = 1'b1, lo = 1'b1, rl = 1'b1, hi = 1'b0, tog = 1'b0;
	logic pf = 1'b1, nf = 1'b1, pr = 1'b0, nr = 1'b0, want = 1'b1, drv = 1'b1;
	logic [4:0] flt = 5'h00;
	logic en, good, sw, goe, ssa;
	logic [2:0] md, cs;
	int miscompares = 0, compares = 0;
	ispfsm_top #(.SS_TIMEOUT(50), .SS_RAMP(10), .PG_DEGLITCH(20)) uut (.i_mclk(clk), .i_reset(rst),
		.i_input_low_lockout(lo), .i_input_reset_level(rl), .i_input_high_lockout(hi), .i_pos_low_fall(pf),
		.i_neg_low_fall(nf), .i_pos_low_rise(pr), .i_neg_low_rise(nr), .i_pos_high_rise(flt[0]),
		.i_neg_high_rise(flt[1]), .i_rail_failsafe(flt[2]), .i_primary_hot(flt[3]), .i_secondary_hot(flt[4]),
		.i_converter_on_request(en), .i_converter_on_request_driven(drv), .o_switch_enable(sw),
		.o_softstart_start(), .o_softstart_active(ssa), .o_supply_good_n_out(), .o_supply_good_n_oe(goe),
		.o_mode(md), .o_latch_cause(cs));
	ispfsm_host host (.i_mclk(clk), .i_want_on(want), .i_toggle(tog), .i_pin_oe(goe), .o_on_request(en),
		.o_good(good));
	initial forever #5 clk = ~clk;
	task automatic chk(input logic [2:0] got, input logic [2:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wmode(input logic [2:0] m, input int lim);
		for (int i = 0; i < lim && md !== m; i++) @(negedge clk);
		chk(md, m);
	endtask
	task automatic toggle;
		tog = 1'b1;
		cyc(1);
		tog = 1'b0;
	endtask
	task automatic power_up;
		lo = 1'b0;
		rl = 1'b0;
		wmode(3'h2, 10);
		chk({2'h0, sw}, 3'h1);
		chk({2'h0, ssa}, 3'h1);
		cyc(6);
		chk(md, 3'h2);
		pf = 1'b0;
		nf = 1'b0;
		pr = 1'b1;
		nr = 1'b1;
		wmode(3'h3, 30);
		chk({2'h0, good}, 3'h0);
		cyc(25);
		chk({2'h0, good}, 3'h1);
		chk({2'h0, ssa}, 3'h0);
	endtask
	task automatic input_over;
		hi = 1'b1;
		wmode(3'h0, 8);
		hi = 1'b0;
		wmode(3'h2, 8);
		want = 1'b0;
		wmode(3'h1, 8);
		hi = 1'b1;
		cyc(6);
		hi = 1'b0;
		cyc(8);
		chk(md, 3'h1);
		chk({1'b0, sw, goe}, 3'h0);
		drv = 1'b0;
		want = 1'b1;
		cyc(8);
		chk(md, 3'h1);
		drv = 1'b1;
		wmode(3'h3, 40);
	endtask
	task automatic under_latch;
		nf = 1'b1;
		nr = 1'b0;
		wmode(3'h4, 8);
		chk(cs, 3'h1);
		chk({2'h0, good}, 3'h0);
		nf = 1'b0;
		nr = 1'b1;
		cyc(10);
		chk(md, 3'h4);
		toggle;
		wmode(3'h3, 40);
	endtask
	task automatic latch_faults;
		logic [2:0] exp [5] = '{3'h2, 3'h2, 3'h3, 3'h4, 3'h4};
		for (int k = 0; k < 5; k++) begin
			flt = 5'h01 << k;
			wmode(3'h4, 8);
			chk(cs, exp[k]);
			toggle;
			cyc(15);
			chk(md, 3'h4);
			flt = 5'h00;
			cyc(8);
			chk(md, 3'h4);
			toggle;
			wmode(3'h3, 40);
		end
	endtask
	task automatic soft_fail;
		pr = 1'b0;
		nr = 1'b0;
		toggle;
		wmode(3'h4, 80);
		chk(cs, 3'h5);
		hi = 1'b1;
		cyc(6);
		hi = 1'b0;
		wmode(3'h4, 10);
		chk(cs, 3'h5);
		pr = 1'b1;
		toggle;
		wmode(3'h2, 20);
		wmode(3'h4, 40);
		chk(cs, 3'h1);
		lo = 1'b1;
		rl = 1'b1;
		wmode(3'h0, 8);
		cyc(4);
		chk(cs, 3'h0);
		nr = 1'b1;
		lo = 1'b0;
		rl = 1'b0;
		wmode(3'h2, 8);
	endtask
	task automatic conclude;
		if (miscompares == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Whole run needs about five hundred cycles
	initial begin
		repeat (5000) @(posedge clk);
		miscompares++;
		conclude;
	end
	initial begin
		cyc(6);
		rst = 1'b0;
		power_up;
		input_over;
		under_latch;
		latch_faults;
		soft_fail;
		conclude;
	end
endmodule
`default_nettype wire
